// [hdl/dplcr_pkg.sv]
// Constants and types for the loop mode and filter configuration register bank
package dplcr_pkg;
   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_STATUS = 8'h52;
   localparam logic [7:0] IDX_PMODE = 8'h53;
   localparam logic [7:0] IDX_AMODE = 8'h54;
   localparam logic [7:0] IDX_PATH = 8'h55;
   localparam logic [7:0] IDX_START = 8'h56;
   localparam logic [7:0] IDX_ACQ = 8'h57;
   localparam logic [7:0] IDX_LOCK = 8'h58;
   localparam logic [7:0] IDX_STAGE = 8'h59;
   localparam logic [7:0] IDX_COARSE = 8'h5a;
   localparam logic [7:0] IDX_FINE = 8'h5b;
   localparam logic [7:0] IDX_HOLD = 8'h5c;
   localparam int ADDR_W = 12;
   // Reset values
   localparam logic [7:0] RST_STATUS = 8'h81;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_PATH = 8'h00;
   localparam logic [7:0] RST_FILTER = 8'h6e;
   localparam logic [7:0] RST_STAGE = 8'h88;
   localparam logic [7:0] RST_COARSE = 8'h85;
   localparam logic [7:0] RST_FINE = 8'h82;
   localparam logic [7:0] RST_HOLD = 8'h44;
   // Writable bits per register
   localparam logic [7:0] WM_MODE = 8'h07;
   localparam logic [7:0] WM_PATH = 8'hff;
   localparam logic [7:0] WM_FILTER = 8'hff;
   localparam logic [7:0] WM_STAGE = 8'h88;
   localparam logic [7:0] WM_COARSE = 8'hff;
   localparam logic [7:0] WM_FINE = 8'hc7;
   localparam logic [7:0] WM_HOLD = 8'hfc;
   // Field positions
   localparam int B_FSYNC = 7;
   localparam int B_ALOCK = 6;
   localparam int B_PSOFT = 5;
   localparam int B_ASOFT = 4;
   localparam int B_PLOCK = 3;
   localparam int B_AUTO_BW = 7;
   localparam int B_FREEZE = 3;
   localparam int B_COARSE_EN = 7;
   localparam int B_WIDE_EN = 6;
   localparam int B_MULTI_APPLY = 5;
   localparam int B_LOW_RATE_EN = 4;
   localparam int B_FINE_EN = 7;
   localparam int B_FAST_EN = 6;
   localparam int B_MAN_HOLD = 7;
   localparam int B_AUTO_AVERAGE_EN = 6;
   localparam int B_FAST_AVERAGE_SEL = 5;
   localparam int B_READ_AVG = 4;
   // Codes
   localparam logic [2:0] MODE_AUTO = 3'h0;
   localparam logic [2:0] MODE_RSVD = 3'h3;
   localparam logic [4:0] UI_ONE = 5'h01;
   localparam logic [3:0] COARSE_MAX_CODE = 4'h3;
   typedef enum logic [1:0] {STAGE_START, STAGE_ACQ, STAGE_LOCKED} dplcr_stage_t;
   typedef enum logic [1:0] {HOLD_MANUAL, HOLD_INSTANT, HOLD_SLOW, HOLD_FAST} dplcr_hold_t;
endpackage

// [hdl/dplcr_top.sv]
// APB register bank for loop mode, status, filter and phase loss settings
//
// Operation
// RULE1: Status reports primary loop mode code
// RULE2: Status bit 6 shows auxiliary lock
// RULE3: Status bit 3 shows primary lock
// RULE4: Bits 5 and 4 show soft alarms
// RULE5: Bit 7 shows frame sync alarm
// RULE6: Primary mode control: automatic or forced
// RULE7: Auxiliary mode control: automatic or forced
// RULE8: Four-bit analog PLL source select
// RULE9: Multi-rate path output clock select
// RULE10: PDH path output clock select
// RULE11: Select low bits strapped from pin
// RULE12: Damping fields use three-bit codes
// RULE13: Bandwidth fields use five-bit ladder
// RULE14: Auto staging picks stage filter settings
// RULE15: Integral freeze at hard limit
// RULE16: Coarse loss unlocks when enabled
// RULE17: Coarse limit code decodes to UI
// RULE18: Low-rate inputs need both enables
// RULE19: Fine loss unlocks when enabled
// RULE20: Fast loss unlock and temporary holdover
// RULE21: Fine loss window code passed through
// RULE22: Holdover offset acquisition method select
// RULE23: Status read live, writes ignored
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module dplcr_top
   import dplcr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dplcr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Strap pin
   input wire logic sonet_sdh_pin,
   // Live loop state
   input wire logic [2:0] primary_mode_status,
   input wire logic primary_loop_locked,
   input wire logic aux_loop_locked,
   input wire logic primary_soft_alarm,
   input wire logic aux_soft_alarm,
   input wire logic frame_sync_alarm_flag,
   input wire dplcr_pkg::dplcr_stage_t primary_stage,
   // Loss and limit events
   input wire logic primary_coarse_loss,
   input wire logic aux_coarse_loss,
   input wire logic primary_fine_loss,
   input wire logic aux_fine_loss,
   input wire logic primary_fast_loss,
   input wire logic aux_fast_loss,
   input wire logic hard_limit_reached,
   input wire logic input_is_low_rate,
   // Mode and path controls
   output logic [2:0] primary_mode_request,
   output logic [2:0] aux_mode_request,
   output logic [3:0] analog_pll_source_sel,
   output logic [1:0] multirate_path_out_sel,
   output logic [1:0] pdh_path_out_sel,
   // Loop filter controls
   output logic [4:0] active_bandwidth_code,
   output logic [2:0] active_damping_code,
   output logic freeze_integral,
   // Phase loss controls
   output logic [4:0] coarse_limit_ui,
   output logic multi_ui_apply,
   output logic [2:0] fine_loss_window,
   output logic primary_unlock,
   output logic aux_unlock,
   output logic primary_temp_holdover,
   // Holdover controls
   output dplcr_pkg::dplcr_hold_t holdover_method,
   output logic [1:0] temp_holdover_method,
   output logic read_averaged
);
   import dplcr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] status_reg, status_next;
   logic [7:0] pmode_reg, amode_reg, path_reg, start_reg, acq_reg, lock_reg;
   logic [7:0] stage_reg, coarse_reg, fine_reg, hold_reg;
   logic pin_meta_reg, pin_sync_reg;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire [7:0] idx = paddr[9:2];
   wire aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
   wire mapped = aligned && (idx >= IDX_STATUS) && (idx <= IDX_HOLD);
   wire access = psel && penable && !pready_reg;
   wire wr_en = psel && penable && pready_reg && pwrite && pstrb[0] && mapped;
   wire [7:0] wd = pwdata[7:0];

   function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] dat, input logic [7:0] msk);
      wmerge = (old & ~msk) | (dat & msk);
   endfunction

   wire [7:0] rd_byte =
      (idx == IDX_STATUS) ? status_reg :
      (idx == IDX_PMODE) ? pmode_reg :
      (idx == IDX_AMODE) ? amode_reg :
      (idx == IDX_PATH) ? path_reg :
      (idx == IDX_START) ? start_reg :
      (idx == IDX_ACQ) ? acq_reg :
      (idx == IDX_LOCK) ? lock_reg :
      (idx == IDX_STAGE) ? stage_reg :
      (idx == IDX_COARSE) ? coarse_reg :
      (idx == IDX_FINE) ? fine_reg : hold_reg;

   // One wait state, then the answer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= access;
         pslverr_reg <= access && !mapped;
         prdata_reg <= (access && !pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Live status
   assign status_next = {frame_sync_alarm_flag, aux_loop_locked, primary_soft_alarm, aux_soft_alarm, //RULE2 RULE4 RULE5
                         primary_loop_locked, primary_mode_status}; //RULE1 RULE3

   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_reg <= RST_STATUS;
      end else begin
         status_reg <= status_next; //RULE23
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser, no reset so the pin is caught during reset
   always_ff @(posedge clk) begin
      pin_meta_reg <= sonet_sdh_pin;
      pin_sync_reg <= pin_meta_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers, reserved bits masked off
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pmode_reg <= RST_MODE;
         amode_reg <= RST_MODE;
         path_reg <= RST_PATH | {5'h00, pin_sync_reg, 1'b0, pin_sync_reg}; //RULE11
         start_reg <= RST_FILTER;
         acq_reg <= RST_FILTER;
         lock_reg <= RST_FILTER;
         stage_reg <= RST_STAGE;
         coarse_reg <= RST_COARSE;
         fine_reg <= RST_FINE;
         hold_reg <= RST_HOLD;
      end else if (wr_en) begin
         if (idx == IDX_PMODE) pmode_reg <= wmerge(pmode_reg, wd, WM_MODE); //RULE23
         if (idx == IDX_AMODE) amode_reg <= wmerge(amode_reg, wd, WM_MODE);
         if (idx == IDX_PATH) path_reg <= wmerge(path_reg, wd, WM_PATH);
         if (idx == IDX_START) start_reg <= wmerge(start_reg, wd, WM_FILTER);
         if (idx == IDX_ACQ) acq_reg <= wmerge(acq_reg, wd, WM_FILTER);
         if (idx == IDX_LOCK) lock_reg <= wmerge(lock_reg, wd, WM_FILTER);
         if (idx == IDX_STAGE) stage_reg <= wmerge(stage_reg, wd, WM_STAGE);
         if (idx == IDX_COARSE) coarse_reg <= wmerge(coarse_reg, wd, WM_COARSE);
         if (idx == IDX_FINE) fine_reg <= wmerge(fine_reg, wd, WM_FINE);
         if (idx == IDX_HOLD) hold_reg <= wmerge(hold_reg, wd, WM_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode and path decode
   wire [2:0] pmode_dec = (pmode_reg[2:0] == MODE_RSVD) ? MODE_AUTO : pmode_reg[2:0]; //RULE6
   wire [2:0] amode_dec = (amode_reg[2:0] == MODE_RSVD) ? MODE_AUTO : amode_reg[2:0]; //RULE7
   wire [3:0] analog_pll_dec = path_reg[7] ? 4'h0 : path_reg[7:4]; //RULE8

   ////////////////////////////////////////////////////////////////////////////
   // Stage filter selection
   logic [7:0] stage_filter;
   always_comb begin
      stage_filter = lock_reg;
      if (stage_reg[B_AUTO_BW]) begin //RULE14
         unique case (primary_stage)
            STAGE_START: stage_filter = start_reg;
            STAGE_ACQ: stage_filter = acq_reg;
            STAGE_LOCKED: stage_filter = lock_reg;
            default: stage_filter = lock_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase loss decode
   wire [3:0] coarse_code = coarse_reg[3:0];
   wire [4:0] coarse_field_ui = (coarse_code <= COARSE_MAX_CODE) ?
                                5'((5'h02 << coarse_code[1:0]) - 5'h01) : UI_ONE; //RULE17
   wire coarse_use_field = input_is_low_rate ?
                           (coarse_reg[B_LOW_RATE_EN] && coarse_reg[B_WIDE_EN]) : coarse_reg[B_WIDE_EN]; //RULE18
   wire p_unlock = (coarse_reg[B_COARSE_EN] && primary_coarse_loss) //RULE16
                   || (fine_reg[B_FINE_EN] && primary_fine_loss) //RULE19
                   || (fine_reg[B_FAST_EN] && primary_fast_loss); //RULE20
   wire a_unlock = (coarse_reg[B_COARSE_EN] && aux_coarse_loss)
                   || (fine_reg[B_FINE_EN] && aux_fine_loss)
                   || (fine_reg[B_FAST_EN] && aux_fast_loss);

   ////////////////////////////////////////////////////////////////////////////
   // Holdover method decode
   dplcr_hold_t hold_dec;
   always_comb begin
      if (hold_reg[B_MAN_HOLD]) hold_dec = HOLD_MANUAL; //RULE22
      else if (!hold_reg[B_AUTO_AVERAGE_EN]) hold_dec = HOLD_INSTANT;
      else if (hold_reg[B_FAST_AVERAGE_SEL]) hold_dec = HOLD_FAST;
      else hold_dec = HOLD_SLOW;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered control outputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         primary_mode_request <= MODE_AUTO;
         aux_mode_request <= MODE_AUTO;
         analog_pll_source_sel <= 4'h0;
         multirate_path_out_sel <= 2'h0;
         pdh_path_out_sel <= 2'h0;
         active_bandwidth_code <= 5'h00;
         active_damping_code <= 3'h0;
         freeze_integral <= 1'b0;
         coarse_limit_ui <= UI_ONE;
         multi_ui_apply <= 1'b0;
         fine_loss_window <= 3'h0;
         primary_unlock <= 1'b0;
         aux_unlock <= 1'b0;
         primary_temp_holdover <= 1'b0;
         holdover_method <= HOLD_SLOW;
         temp_holdover_method <= 2'h0;
         read_averaged <= 1'b0;
      end else begin
         primary_mode_request <= pmode_dec; //RULE6
         aux_mode_request <= amode_dec; //RULE7
         analog_pll_source_sel <= analog_pll_dec; //RULE8
         multirate_path_out_sel <= path_reg[3:2]; //RULE9
         pdh_path_out_sel <= path_reg[1:0]; //RULE10
         active_bandwidth_code <= stage_filter[4:0]; //RULE13
         active_damping_code <= stage_filter[7:5]; //RULE12
         freeze_integral <= stage_reg[B_FREEZE] && hard_limit_reached; //RULE15
         coarse_limit_ui <= coarse_use_field ? coarse_field_ui : UI_ONE; //RULE18
         multi_ui_apply <= coarse_reg[B_MULTI_APPLY];
         fine_loss_window <= fine_reg[2:0]; //RULE21
         primary_unlock <= p_unlock;
         aux_unlock <= a_unlock;
         primary_temp_holdover <= fine_reg[B_FAST_EN] && primary_fast_loss; //RULE20
         holdover_method <= hold_dec; //RULE22
         temp_holdover_method <= hold_reg[3:2];
         read_averaged <= hold_reg[B_READ_AVG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_mode_status_live: //RULE1
   assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> status_reg[2:0] == $past(primary_mode_status))
      else $error("mode status not live");

   a_lock_bits_live: //RULE2
   assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> status_reg[B_ALOCK] == $past(aux_loop_locked) && status_reg[B_PLOCK] == $past(primary_loop_locked))
      else $error("lock bits wrong");

   a_alarm_bits_live: //RULE5
   assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> status_reg[B_FSYNC] == $past(frame_sync_alarm_flag)
         && status_reg[B_PSOFT] == $past(primary_soft_alarm) && status_reg[B_ASOFT] == $past(aux_soft_alarm))
      else $error("alarm bits wrong");

   a_mode_force_write: //RULE6
   assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && idx == IDX_PMODE && wd[2:0] != MODE_RSVD) |=> ##1 primary_mode_request == $past(wd[2:0], 2))
      else $error("forced mode not applied");

   a_locked_only_filter: //RULE14
   assert property (@(posedge clk) disable iff (!resetn)
      (!stage_reg[B_AUTO_BW] && !wr_en) |=> active_bandwidth_code == $past(lock_reg[4:0])
         && active_damping_code == $past(lock_reg[7:5]))
      else $error("non-locked filter used");

   a_freeze_at_limit: //RULE15
   assert property (@(posedge clk) disable iff (!resetn)
      (hard_limit_reached && !stage_reg[B_FREEZE]) |=> !freeze_integral)
      else $error("integral frozen while disabled");

   a_no_unlock_disabled: //RULE19
   assert property (@(posedge clk) disable iff (!resetn)
      (!coarse_reg[B_COARSE_EN] && !fine_reg[B_FINE_EN] && !fine_reg[B_FAST_EN]) |=> !primary_unlock && !aux_unlock)
      else $error("unlock while all enables off");

   a_low_rate_one_ui: //RULE18
   assert property (@(posedge clk) disable iff (!resetn)
      (input_is_low_rate && !coarse_reg[B_LOW_RATE_EN]) |=> coarse_limit_ui == UI_ONE)
      else $error("low rate limit not one UI");

   a_status_write_ignored: //RULE23
   assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && idx == IDX_STATUS) |=> $stable(pmode_reg) && $stable(fine_reg) && $stable(coarse_reg))
      else $error("status write changed control");

   a_apb_one_wait: //RULE23
   assert property (@(posedge clk) disable iff (!resetn)
      access |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   a_aux_mode_force: //RULE7
   assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && idx == IDX_AMODE && wd[2:0] != MODE_RSVD) |=> ##1 aux_mode_request == $past(wd[2:0], 2))
      else $error("aux forced mode not applied");

   a_reserved_mode_auto: //RULE6
   assert property (@(posedge clk) disable iff (!resetn)
      (wr_en && idx == IDX_PMODE && wd[2:0] == MODE_RSVD) |=> ##1 primary_mode_request == MODE_AUTO)
      else $error("reserved mode not automatic");

   a_source_select: //RULE8
   assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> !analog_pll_source_sel[3]
         && (analog_pll_source_sel == $past(path_reg[7:4]) || $past(path_reg[7])))
      else $error("analog source select wrong");

   a_path_out_sel: //RULE9 RULE10
   assert property (@(posedge clk) disable iff (!resetn)
      resetn |=> {multirate_path_out_sel, pdh_path_out_sel} == $past(path_reg[3:0]))
      else $error("path output select wrong");

   a_strap_low_bits: //RULE11
   assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> path_reg == (RST_PATH | {5'h00, $past(pin_sync_reg), 1'b0, $past(pin_sync_reg)}))
      else $error("strap bits not taken");

   a_acq_stage_pick: //RULE12 RULE13 RULE14
   assert property (@(posedge clk) disable iff (!resetn)
      (stage_reg[B_AUTO_BW] && primary_stage == STAGE_ACQ)
         |=> {active_damping_code, active_bandwidth_code} == $past(acq_reg))
      else $error("acquisition filter not used");

   a_freeze_enabled: //RULE15
   assert property (@(posedge clk) disable iff (!resetn)
      (hard_limit_reached && stage_reg[B_FREEZE]) |=> freeze_integral)
      else $error("integral not frozen at limit");

   a_coarse_unlock: //RULE16
   assert property (@(posedge clk) disable iff (!resetn)
      (coarse_reg[B_COARSE_EN] && primary_coarse_loss) |=> primary_unlock)
      else $error("coarse loss did not unlock");

   a_aux_fine_unlock: //RULE19
   assert property (@(posedge clk) disable iff (!resetn)
      (fine_reg[B_FINE_EN] && aux_fine_loss) |=> aux_unlock)
      else $error("fine loss did not unlock aux");

   a_fast_loss_hold: //RULE20
   assert property (@(posedge clk) disable iff (!resetn)
      (fine_reg[B_FAST_EN] && primary_fast_loss) |=> primary_unlock && primary_temp_holdover)
      else $error("fast loss not acted on");

   a_coarse_field_ui: //RULE17 RULE18
   assert property (@(posedge clk) disable iff (!resetn)
      (!input_is_low_rate && coarse_reg[B_WIDE_EN] && coarse_reg[3:0] == 4'h2) |=> coarse_limit_ui == 5'h07)
      else $error("coarse field limit wrong");

   a_manual_holdover: //RULE22
   assert property (@(posedge clk) disable iff (!resetn)
      hold_reg[B_MAN_HOLD] |=> holdover_method == HOLD_MANUAL)
      else $error("manual holdover not chosen");
endmodule

// [tb/tb_dplcr_top.sv]
// Self-checking bench for the loop mode and filter register bank
`timescale 1ns/10ps
module tb_dplcr_top;
   import dplcr_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, sonet_sdh_pin, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, analog_pll_source_sel;
   logic [2:0] primary_mode_status, primary_mode_request, aux_mode_request, active_damping_code, fine_loss_window;
   logic primary_loop_locked, aux_loop_locked, primary_soft_alarm, aux_soft_alarm, frame_sync_alarm_flag;
   logic primary_coarse_loss, aux_coarse_loss, primary_fine_loss, aux_fine_loss, primary_fast_loss, aux_fast_loss;
   logic hard_limit_reached, input_is_low_rate, freeze_integral, multi_ui_apply;
   logic primary_unlock, aux_unlock, primary_temp_holdover, read_averaged;
   logic [1:0] multirate_path_out_sel, pdh_path_out_sel, temp_holdover_method;
   logic [4:0] active_bandwidth_code, coarse_limit_ui;
   dplcr_stage_t primary_stage;
   dplcr_hold_t holdover_method;
   logic [7:0] mdl [8'h52:8'h5c];
   logic [11:0] bad [4] = '{12'h174, 12'h149, 12'h548, 12'h144};
   integer mismatches = 0, check_count = 0, seed = 32'h2693, i, k;

   dplcr_top dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
      .sonet_sdh_pin, .primary_mode_status, .primary_loop_locked, .aux_loop_locked, .primary_soft_alarm,
      .aux_soft_alarm, .frame_sync_alarm_flag, .primary_stage, .primary_coarse_loss, .aux_coarse_loss,
      .primary_fine_loss, .aux_fine_loss, .primary_fast_loss, .aux_fast_loss, .hard_limit_reached,
      .input_is_low_rate, .primary_mode_request, .aux_mode_request, .analog_pll_source_sel,
      .multirate_path_out_sel, .pdh_path_out_sel, .active_bandwidth_code, .active_damping_code,
      .freeze_integral, .coarse_limit_ui, .multi_ui_apply, .fine_loss_window, .primary_unlock, .aux_unlock,
      .primary_temp_holdover, .holdover_method, .temp_holdover_method, .read_averaged);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [7:0] wm(input logic [7:0] x);
      case (x)
         IDX_PMODE, IDX_AMODE: return WM_MODE;
         IDX_STAGE: return WM_STAGE;
         IDX_FINE: return WM_FINE;
         IDX_HOLD: return WM_HOLD;
         default: return 8'hff;
      endcase
   endfunction

   task automatic wr(input logic [7:0] x, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, {2'b00, x, 2'b00}, d, s);
      cmp(err, 1'b0);
      if (s[0] && x != IDX_STATUS) begin
         mdl[x] = (mdl[x] & ~wm(x)) | (d[7:0] & wm(x));
      end
   endtask

   task automatic rdc(input logic [7:0] x);
      logic [7:0] e;
      apb(1'b0, {2'b00, x, 2'b00}, 32'h0, 4'h0);
      e = x == IDX_STATUS ? {frame_sync_alarm_flag, aux_loop_locked, primary_soft_alarm, aux_soft_alarm,
         primary_loop_locked, primary_mode_status} : mdl[x];
      cmp(rd, {24'h0, e});
      cmp(err, 1'b0);
   endtask

   task automatic rnd_in();
      int s;
      @(posedge clk);
      {primary_mode_status, primary_loop_locked, aux_loop_locked, primary_soft_alarm, aux_soft_alarm,
         frame_sync_alarm_flag, primary_coarse_loss, aux_coarse_loss, primary_fine_loss, aux_fine_loss,
         primary_fast_loss, aux_fast_loss, hard_limit_reached, input_is_low_rate} <= 16'($random(seed));
      s = $unsigned($random(seed)) % 3;
      primary_stage <= dplcr_stage_t'(s[1:0]);
   endtask

   // Decoded outputs against the model, on the falling edge two cycles after their cause
   task automatic chk_out();
      logic [7:0] c, f, h, r;
      logic ap;
      repeat (2) @(posedge clk);
      @(negedge clk);
      c = mdl[IDX_COARSE];
      f = mdl[IDX_FINE];
      h = mdl[IDX_HOLD];
      r = (!mdl[IDX_STAGE][7] || primary_stage == STAGE_LOCKED) ? mdl[IDX_LOCK] :
         (primary_stage == STAGE_ACQ) ? mdl[IDX_ACQ] : mdl[IDX_START];
      ap = input_is_low_rate ? c[6] & c[4] : c[6];
      cmp(primary_mode_request, mdl[IDX_PMODE][2:0] == 3'h3 ? 3'h0 : mdl[IDX_PMODE][2:0]);
      cmp(aux_mode_request, mdl[IDX_AMODE][2:0] == 3'h3 ? 3'h0 : mdl[IDX_AMODE][2:0]);
      cmp(analog_pll_source_sel, mdl[IDX_PATH][7] ? 4'h0 : mdl[IDX_PATH][7:4]);
      cmp(multirate_path_out_sel, mdl[IDX_PATH][3:2]);
      cmp(pdh_path_out_sel, mdl[IDX_PATH][1:0]);
      cmp({active_damping_code, active_bandwidth_code}, r);
      cmp(freeze_integral, mdl[IDX_STAGE][3] & hard_limit_reached);
      cmp(coarse_limit_ui, (ap && c[3:0] <= 4'h3) ? (5'h2 << c[1:0]) - 5'h1 : 5'h1);
      cmp({multi_ui_apply, fine_loss_window}, {c[5], f[2:0]});
      cmp(primary_unlock, c[7] & primary_coarse_loss | f[7] & primary_fine_loss | f[6] & primary_fast_loss);
      cmp(aux_unlock, c[7] & aux_coarse_loss | f[7] & aux_fine_loss | f[6] & aux_fast_loss);
      cmp(primary_temp_holdover, f[6] & primary_fast_loss);
      cmp(holdover_method, h[7] ? 2'h0 : h[6] ? (h[5] ? 2'h3 : 2'h2) : 2'h1);
      cmp({temp_holdover_method, read_averaged}, {h[3:2], h[4]});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1000000;
      mismatches++;
      end_of_test();
   end

   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      sonet_sdh_pin = 1'b1;
      {primary_loop_locked, aux_loop_locked, primary_soft_alarm, aux_soft_alarm, primary_coarse_loss} = '0;
      {aux_coarse_loss, primary_fine_loss, aux_fine_loss, primary_fast_loss, aux_fast_loss} = '0;
      {hard_limit_reached, input_is_low_rate} = '0;
      frame_sync_alarm_flag = 1'b1;
      primary_mode_status = 3'h1;
      primary_stage = STAGE_START;
      mdl = '{RST_STATUS, RST_MODE, RST_MODE, RST_PATH | 8'h05, RST_FILTER, RST_FILTER, RST_FILTER,
         RST_STAGE, RST_COARSE, RST_FINE, RST_HOLD};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      chk_out();
      // Unmapped, misaligned and out-of-window places answer with an error
      for (i = 0; i < 4; i++) begin
         apb(i[0], bad[i], 32'hff, 4'hf);
         cmp(err, 1'b1);
         cmp(rd, 32'h0);
      end
      wr(IDX_STATUS, 32'h7e, 4'hf);
      for (i = 8'h52; i <= 8'h5c; i++) begin
         rdc(i[7:0]);
      end
      // Every code of the decoded fields
      for (i = 0; i < 256; i++) begin
         wr(IDX_COARSE, i, 4'h1);
         wr(IDX_PATH, i, 4'h1);
         wr(IDX_HOLD, i, 4'h1);
         wr(IDX_PMODE, i, 4'h1);
         wr(IDX_AMODE, ~i, 4'h1);
         rnd_in();
         chk_out();
      end
      // Random traffic, with lane 0 strobe sometimes off
      for (i = 0; i < 400; i++) begin
         k = $unsigned($random(seed)) % 11;
         wr(8'h52 + k[7:0], $random(seed), 4'($random(seed)));
         rnd_in();
         rdc(8'h52 + k[7:0]);
         rdc(IDX_STATUS);
         chk_out();
      end
      // Second reset in mid-run, strap pin low this time
      @(posedge clk);
      resetn <= 1'b0;
      sonet_sdh_pin <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      mdl = '{RST_STATUS, RST_MODE, RST_MODE, RST_PATH, RST_FILTER, RST_FILTER, RST_FILTER,
         RST_STAGE, RST_COARSE, RST_FINE, RST_HOLD};
      chk_out();
      for (i = 8'h52; i <= 8'h5c; i++) begin
         rdc(i[7:0]);
      end
      end_of_test();
   end
endmodule
